//--- src/dcs_pair_timer.sv
// pair timer: raises a pulse every 2^code base steps, silent for code zero
`timescale 1ns/1ps
module dcs_pair_timer
    import dcs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i, // one base step elapsed
    input wire logic [3:0] code_i, // interval code
    output logic expire_o // interval elapsed, one cycle
);

    dcs_timer_t s; // registered state
    dcs_timer_t next_s; // next state

    // =========================================================
    // interval counting
    // =========================================================
    always_comb begin
        logic [15:0] limit;
        limit = (16'h0001 << code_i) - 16'h0001; // RULE9
        next_s = s;
        next_s.expire = 1'b0;
        if (code_i != s.code_q) begin
            // new code restarts the interval
            next_s.cnt = 16'h0000;
            next_s.code_q = code_i;
        end else if (code_i == 4'h0) begin
            next_s.cnt = 16'h0000; // RULE9
        end else if (tick_i) begin
            if (s.cnt == limit) begin
                next_s.cnt = 16'h0000;
                next_s.expire = 1'b1;
            end else begin
                next_s.cnt = s.cnt + 16'h0001;
            end
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.code_q <= INTERVAL_RST;
        end else begin
            s <= next_s;
        end
    end

    assign expire_o = s.expire;

    // a zero code never lets an interval elapse
    property p_off_silent;
        @(posedge clk_i) disable iff (rst_i)
        (code_i == 4'h0) ##1 (code_i == 4'h0) |-> !expire_o;
    endproperty
    a_off_silent: assert property (p_off_silent) // RULE9
        else $error("pair timer expired with code zero");

endmodule : dcs_pair_timer

//--- src/dcs_pkg.sv
// package: register map, reset values, timing and state types of the servo trigger block
package dcs_pkg;

    // =========================================================
    // register indexes (byte address is four times the index)
    // =========================================================
    localparam logic [7:0] IDX_ENABLE = 8'h43; // per-channel servo enables
    localparam logic [7:0] IDX_TRIGGER = 8'h44; // trigger control / progress
    localparam logic [7:0] IDX_INTERVAL = 8'h45; // periodic interval codes
    localparam logic [7:0] IDX_SERIES_LINE = 8'h47; // line pair series count
    localparam logic [7:0] IDX_SERIES_PHONES = 8'h48; // phones pair count
    localparam logic [7:0] IDX_OFFSET_LR = 8'h49; // first offset (line right)
    localparam logic [7:0] IDX_DONE = 8'h4d; // completion flags
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h50; // sticky events
    localparam logic [7:0] IDX_IRQ_MASK = 8'h51; // event mask

    // =========================================================
    // field positions
    // =========================================================
    localparam int SINGLE_LSB = 12; // single trigger bits 15:12
    localparam int SERIES_LSB = 8; // series trigger bits 11:8
    localparam int STARTUP_LSB = 4; // start-up trigger bits 7:4
    localparam int OFFWR_LSB = 0; // offset write trigger bits 3:0
    localparam int LINE_INTERVAL_LSB = 8; // line pair code bits 11:8
    localparam int PHONES_INTERVAL_LSB = 0; // phones pair code bits 3:0
    localparam int DONE_LSB = 8; // completion flags bits 11:8

    // =========================================================
    // reset values
    // =========================================================
    localparam logic [3:0] INTERVAL_RST = 4'ha; // about 262 s
    localparam logic [6:0] SERIES_RST = 7'h2a; // 43 updates

    // =========================================================
    // timing
    // =========================================================
    localparam int unsigned CLK_PERIOD_NS = 8; // 125 MHz
    localparam int unsigned BASE_TIME_NS = 256_000_000; // 0.256 s step
    localparam int unsigned BASE_CYCLES = BASE_TIME_NS / CLK_PERIOD_NS;

    // per-channel correction mode, one-hot
    typedef enum logic [4:0] {
        M_IDLE = 5'h01,
        M_SINGLE = 5'h02,
        M_SERIES = 5'h04,
        M_STARTUP = 5'h08,
        M_OFFWR = 5'h10
    } dcs_mode_t;

    // whole state of the main block
    typedef struct packed {
        logic [3:0] enable; // servo enable per channel
        logic [3:0] interval_line; // line pair interval code
        logic [3:0] interval_phones; // phones pair interval code
        logic [6:0] series_line; // line pair series count
        logic [6:0] series_phones; // phones pair series count
        logic [3:0][7:0] offset; // offsets for offset write mode
        dcs_mode_t [3:0] mode; // running correction per channel
        logic [3:0][7:0] remain; // updates still to do
        logic [3:0] req; // update request pulses
        logic [3:0] done_flags; // start-up / offset write complete
        logic [3:0] irq_status; // sticky finish events
        logic [3:0] irq_mask; // event enables
        logic [31:0] tick_cnt; // base step prescaler
        logic tick; // base step pulse
        logic ack; // bus acknowledge
        logic [31:0] dat; // bus read data
    } dcs_state_t;

    // state of one pair timer
    typedef struct packed {
        logic [15:0] cnt; // base steps elapsed
        logic [3:0] code_q; // code the count belongs to
        logic expire; // interval elapsed pulse
    } dcs_timer_t;

endpackage : dcs_pkg

//--- src/dcs_servo_trigger.sv
// servo trigger block: trigger register, periodic series timers, wishbone slave
//
// Function
// RULE1: writing single bit starts one correction
// RULE2: single bit reads one while running
// RULE3: writing series bit starts correction series
// RULE4: series bit reads one during offset write
// RULE5: start-up bit runs start-up, reads busy
// RULE6: offset write bit applies offset, reads busy
// RULE7: bits 11:8 set line pair interval
// RULE8: bits 3:0 set phones pair interval
// RULE9: interval 0.256 s times 2^code, zero off
// RULE10: both interval codes reset to 1010
// RULE11: corrections only on enabled channels
// RULE12: series performs count plus one updates
// RULE13: completion flag set after start-up/offset write
// RULE14: trigger self-clears, zero writes ignored, independent
// RULE15: triggers zero after reset, nothing runs
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
module dcs_servo_trigger
    import dcs_pkg::*;
#(
    parameter int unsigned BASE_TICK_CYCLES = BASE_CYCLES // 0.256 s
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] update_done_i, // servo finished one update
    output logic [3:0] update_req_o, // start one update, pulse
    output logic [3:0] update_startup_o, // running update is start-up
    output logic [3:0] update_offset_write_o, // running update is offset
    output logic [31:0] offset_value_o, // offsets, channel n at 8n
    output logic [3:0] servo_enable_o, // servo enables
    output logic irq_o // unmasked finish event pending
);

    dcs_state_t s; // registered state
    dcs_state_t next_s; // next state
    logic expire_line; // line pair interval elapsed
    logic expire_phones; // phones pair interval elapsed

    // =========================================================
    // periodic timers
    // =========================================================
    dcs_pair_timer u_line_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(s.tick),
        .code_i(s.interval_line), // RULE7
        .expire_o(expire_line)
    );

    dcs_pair_timer u_phones_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(s.tick),
        .code_i(s.interval_phones), // RULE8
        .expire_o(expire_phones)
    );

    // =========================================================
    // next state
    // =========================================================
    always_comb begin
        logic access; // bus cycle waiting for ack
        logic wr; // write taken this cycle
        logic rd; // read taken this cycle
        logic [7:0] idx; // register index
        logic [15:0] wmask; // byte lane mask
        logic [15:0] trig; // trigger bits written as one
        logic [3:0] finish; // correction finished per channel
        logic periodic; // pair interval elapsed for channel
        logic [6:0] count; // series count for channel
        logic [15:0] progress; // trigger readback
        access = wb_cyc_i && wb_stb_i && !s.ack;
        wr = access && wb_we_i;
        rd = access && !wb_we_i;
        idx = wb_adr_i[9:2];
        wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        trig = (wr && idx == IDX_TRIGGER) ? (wb_dat_i[15:0] & wmask)
                                          : 16'h0000; // RULE14
        finish = 4'h0;
        periodic = 1'b0;
        count = 7'h00;
        progress = 16'h0000;
        next_s = s;
        next_s.req = 4'h0;
        next_s.ack = access;

        // base step prescaler
        next_s.tick = 1'b0;
        if (s.tick_cnt == 32'(BASE_TICK_CYCLES - 1)) begin
            next_s.tick_cnt = 32'h0000_0000;
            next_s.tick = 1'b1; // RULE9
        end else begin
            next_s.tick_cnt = s.tick_cnt + 32'h0000_0001;
        end

        // plain register writes, per byte lane
        if (wr) begin
            case (idx)
                IDX_ENABLE: begin
                    if (wb_sel_i[0]) begin
                        next_s.enable = wb_dat_i[3:0];
                    end
                end
                IDX_INTERVAL: begin
                    if (wb_sel_i[1]) begin
                        next_s.interval_line =
                            wb_dat_i[LINE_INTERVAL_LSB +: 4]; // RULE7
                    end
                    if (wb_sel_i[0]) begin
                        next_s.interval_phones =
                            wb_dat_i[PHONES_INTERVAL_LSB +: 4]; // RULE8
                    end
                end
                IDX_SERIES_LINE: begin
                    if (wb_sel_i[0]) begin
                        next_s.series_line = wb_dat_i[6:0];
                    end
                end
                IDX_SERIES_PHONES: begin
                    if (wb_sel_i[0]) begin
                        next_s.series_phones = wb_dat_i[6:0];
                    end
                end
                IDX_IRQ_MASK: begin
                    if (wb_sel_i[0]) begin
                        next_s.irq_mask = wb_dat_i[3:0];
                    end
                end
                default: begin
                    // other indexes hold nothing writable here
                end
            endcase
        end

        // per-channel correction control, channels fully independent
        for (int ch = 0; ch < 4; ch++) begin
            if (wr && wb_sel_i[0] && idx == IDX_OFFSET_LR + 8'(3 - ch)) begin
                next_s.offset[ch] = wb_dat_i[7:0];
            end
            periodic = (ch >= 2) ? expire_line : expire_phones;
            count = (ch >= 2) ? s.series_line : s.series_phones;
            if (!s.enable[ch]) begin
                next_s.mode[ch] = M_IDLE; // RULE11
                next_s.remain[ch] = 8'h00;
            end else if (s.mode[ch] == M_IDLE) begin
                // a busy channel ignores new triggers until it ends
                if (trig[SINGLE_LSB + ch]) begin
                    next_s.mode[ch] = M_SINGLE; // RULE1
                    next_s.remain[ch] = 8'h01;
                    next_s.req[ch] = 1'b1;
                end else if (trig[SERIES_LSB + ch] || periodic) begin
                    next_s.mode[ch] = M_SERIES; // RULE3
                    next_s.remain[ch] = {1'b0, count} + 8'h01; // RULE12
                    next_s.req[ch] = 1'b1;
                end else if (trig[STARTUP_LSB + ch]) begin
                    next_s.mode[ch] = M_STARTUP; // RULE5
                    next_s.remain[ch] = 8'h01;
                    next_s.req[ch] = 1'b1;
                    next_s.done_flags[ch] = 1'b0;
                end else if (trig[OFFWR_LSB + ch]) begin
                    next_s.mode[ch] = M_OFFWR; // RULE6
                    next_s.remain[ch] = 8'h01;
                    next_s.req[ch] = 1'b1;
                    next_s.done_flags[ch] = 1'b0;
                end
            end else if (update_done_i[ch]) begin
                if (s.remain[ch] <= 8'h01) begin
                    // last update: progress bit clears itself
                    next_s.mode[ch] = M_IDLE; // RULE14
                    next_s.remain[ch] = 8'h00;
                    finish[ch] = 1'b1;
                    if (s.mode[ch] == M_STARTUP || s.mode[ch] == M_OFFWR) begin
                        next_s.done_flags[ch] = 1'b1; // RULE13
                    end
                end else begin
                    next_s.remain[ch] = s.remain[ch] - 8'h01; // RULE12
                    next_s.req[ch] = 1'b1;
                end
            end
        end

        // sticky events: read clears, a new event wins over the clear
        if (rd && idx == IDX_IRQ_STATUS) begin
            next_s.irq_status = finish;
        end else begin
            next_s.irq_status = s.irq_status | finish;
        end

        // read data, taken with the ack
        for (int ch = 0; ch < 4; ch++) begin
            progress[SINGLE_LSB + ch] = (s.mode[ch] == M_SINGLE); // RULE2
            progress[SERIES_LSB + ch] = (s.mode[ch] == M_SERIES) ||
                                        (s.mode[ch] == M_OFFWR); // RULE4
            progress[STARTUP_LSB + ch] = (s.mode[ch] == M_STARTUP); // RULE5
            progress[OFFWR_LSB + ch] = (s.mode[ch] == M_OFFWR); // RULE6
        end
        next_s.dat = 32'h0000_0000;
        if (rd) begin
            case (idx)
                IDX_ENABLE: next_s.dat[3:0] = s.enable;
                IDX_TRIGGER: next_s.dat[15:0] = progress;
                IDX_INTERVAL: begin
                    next_s.dat[LINE_INTERVAL_LSB +: 4] = s.interval_line;
                    next_s.dat[PHONES_INTERVAL_LSB +: 4] = s.interval_phones;
                end
                IDX_SERIES_LINE: next_s.dat[6:0] = s.series_line;
                IDX_SERIES_PHONES: next_s.dat[6:0] = s.series_phones;
                IDX_OFFSET_LR: next_s.dat[7:0] = s.offset[3];
                IDX_OFFSET_LR + 8'h01: next_s.dat[7:0] = s.offset[2];
                IDX_OFFSET_LR + 8'h02: next_s.dat[7:0] = s.offset[1];
                IDX_OFFSET_LR + 8'h03: next_s.dat[7:0] = s.offset[0];
                IDX_DONE: next_s.dat[DONE_LSB +: 4] = s.done_flags;
                IDX_IRQ_STATUS: next_s.dat[3:0] = s.irq_status;
                IDX_IRQ_MASK: next_s.dat[3:0] = s.irq_mask;
                default: next_s.dat = 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    // =========================================================
    // state register
    // =========================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.mode <= {4{M_IDLE}}; // RULE15
            s.interval_line <= INTERVAL_RST; // RULE10
            s.interval_phones <= INTERVAL_RST; // RULE10
            s.series_line <= SERIES_RST;
            s.series_phones <= SERIES_RST;
        end else begin
            s <= next_s;
        end
    end

    // =========================================================
    // outputs
    // =========================================================
    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.dat;
    assign update_req_o = s.req;
    assign offset_value_o = s.offset;
    assign servo_enable_o = s.enable;
    assign irq_o = |(s.irq_status & s.irq_mask);

    // mode decode for the analogue servo
    for (genvar ch = 0; ch < 4; ch++) begin : g_mode
        assign update_startup_o[ch] = (s.mode[ch] == M_STARTUP);
        assign update_offset_write_o[ch] = (s.mode[ch] == M_OFFWR);
    end

    // =========================================================
    // checks
    // =========================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // write of single bit 12 taken on an idle enabled channel
    sequence s_single_write;
        wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[1] &&
        wb_adr_i[9:2] == IDX_TRIGGER && wb_dat_i[12] &&
        s.enable[0] && s.mode[0] == M_IDLE && !wb_dat_i[8];
    endsequence

    property p_single_start;
        s_single_write |=> s.mode[0] == M_SINGLE && update_req_o[0];
    endproperty
    a_single_start: assert property (p_single_start) // RULE1
        else $error("single trigger did not start a correction");

    property p_single_read;
        wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o &&
        wb_adr_i[9:2] == IDX_TRIGGER && s.mode[0] == M_SINGLE
        |=> wb_ack_o && wb_dat_o[12];
    endproperty
    a_single_read: assert property (p_single_read) // RULE2
        else $error("single progress bit read as zero");

    property p_series_len;
        s.mode[1] == M_IDLE ##1 s.mode[1] == M_SERIES |->
        s.remain[1] == {1'b0, $past(s.series_phones)} + 8'h01;
    endproperty
    a_series_len: assert property (p_series_len) // RULE12
        else $error("series length is not count plus one");

    property p_series_step;
        s.mode[1] == M_SERIES && update_done_i[1] && s.enable[1] &&
        s.remain[1] > 8'h01
        |=> update_req_o[1] && s.remain[1] == $past(s.remain[1]) - 8'h01;
    endproperty
    a_series_step: assert property (p_series_step) // RULE3
        else $error("series did not request the next update");

    property p_offwr_read;
        s.mode[3] == M_OFFWR && wb_cyc_i && wb_stb_i && !wb_we_i &&
        !wb_ack_o && wb_adr_i[9:2] == IDX_TRIGGER
        |=> wb_dat_o[11] && wb_dat_o[3];
    endproperty
    a_offwr_read: assert property (p_offwr_read) // RULE4
        else $error("offset write progress not shown");

    property p_done_flag;
        s.mode[2] == M_STARTUP && update_done_i[2] && s.enable[2] &&
        s.remain[2] == 8'h01
        |=> s.done_flags[2] && s.mode[2] == M_IDLE ##1 s.done_flags[2];
    endproperty
    a_done_flag: assert property (p_done_flag) // RULE13
        else $error("start-up finish did not set completion flag");

    property p_disabled_idle;
        !s.enable[3] |=> s.mode[3] == M_IDLE && !update_req_o[3];
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) // RULE11
        else $error("correction on a disabled channel");

    property p_reset_values;
        @(posedge clk_i) disable iff (1'b0)
        $past(rst_i) && !rst_i |-> s.interval_line == INTERVAL_RST &&
        s.interval_phones == INTERVAL_RST && s.mode == {4{M_IDLE}};
    endproperty
    a_reset_values: assert property (p_reset_values) // RULE10
        else $error("wrong values after reset");

endmodule : dcs_servo_trigger

//--- test/dcs_servo_trigger_bench.sv
// bench: drives the servo trigger block over wishbone and checks its answers
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module dcs_servo_trigger_bench
    import dcs_pkg::*;
();
    // =========================================================
    // signals and bench state
    // =========================================================
    localparam int unsigned TICK = 4; // shortened base step
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [9:0] wb_adr_i = 10'h000;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [3:0] update_done_i = 4'h0;
    logic [3:0] man_done = 4'h0; // hand-made finish pulses
    logic wb_ack_o, irq_o;
    logic [31:0] wb_dat_o, offset_value_o, rd;
    logic [3:0] update_req_o, update_startup_o, update_offset_write_o;
    logic [3:0] servo_enable_o, ack_req; // requests seen with the ack
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    bit auto_done = 1'b0; // servo answers every request one cycle later
    int req_cnt[4] = '{0, 0, 0, 0};
    int last_req[4] = '{0, 0, 0, 0};
    int gap[4] = '{0, 0, 0, 0};
    int n;

    dcs_servo_trigger #(.BASE_TICK_CYCLES(TICK)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o), .update_done_i(update_done_i),
        .update_req_o(update_req_o), .update_startup_o(update_startup_o),
        .update_offset_write_o(update_offset_write_o),
        .offset_value_o(offset_value_o), .servo_enable_o(servo_enable_o),
        .irq_o(irq_o));

    // clock at 125 MHz
    initial begin
        forever #4 clk_i = ~clk_i;
    end

    // servo stand-in, request counter per channel and hang guard
    always @(posedge clk_i) begin
        cycles++;
        update_done_i <= man_done | (auto_done ? update_req_o : 4'h0);
        for (int c = 0; c < 4; c++) begin
            if (update_req_o[c] === 1'b1) begin
                req_cnt[c]++;
                gap[c] = cycles - last_req[c];
                last_req[c] = cycles;
            end
        end
        if (cycles > 5000) begin
            n_mismatch++;
            end_sim();
        end
    end

    // =========================================================
    // bus and helper tasks
    // =========================================================
    // one classic cycle; waits for ack, then releases
    task automatic wb(input logic we, input logic [7:0] idx,
                      input logic [31:0] wd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= wd;
        wb_sel_i <= 4'h3;
        // ack and read data are taken at the edge that samples ack high
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        ack_req = update_req_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        wb(1'b1, idx, wd);
    endtask : wr

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        wb(1'b0, idx, 32'h0000_0000);
        `CHK(rd, exp)
    endtask : rd_chk

    // one finish pulse on the masked channels
    task automatic pulse(input logic [3:0] m);
        @(posedge clk_i);
        man_done <= m;
        @(posedge clk_i);
        man_done <= 4'h0;
        repeat (2) @(posedge clk_i);
    endtask : pulse

    // =========================================================
    // scenarios
    // =========================================================
    task automatic t_reset;
        rd_chk(IDX_TRIGGER, 32'h0000_0000);
        rd_chk(IDX_INTERVAL, 32'h0000_0a0a);
        rd_chk(8'hff, 32'h0000_0000); // unmapped place reads zero
        `CHK(req_cnt[0] + req_cnt[1] + req_cnt[2] + req_cnt[3], 0)
    endtask : t_reset

    task automatic t_single_irq;
        wr(IDX_INTERVAL, 32'h0000_0000);
        wr(IDX_ENABLE, 32'h0000_000f);
        wr(IDX_TRIGGER, 32'h0000_1000);
        `CHK(ack_req, 4'h1)
        rd_chk(IDX_TRIGGER, 32'h0000_1000);
        `CHK(irq_o, 1'b0)
        pulse(4'h1);
        rd_chk(IDX_TRIGGER, 32'h0000_0000);
        wr(IDX_IRQ_MASK, 32'h0000_0001);
        @(posedge clk_i);
        #1;
        `CHK(irq_o, 1'b1)
        rd_chk(IDX_IRQ_STATUS, 32'h0000_0001);
        @(posedge clk_i);
        #1;
        `CHK(irq_o, 1'b0)
    endtask : t_single_irq

    task automatic t_disabled_zero;
        wr(IDX_ENABLE, 32'h0000_000e);
        `CHK(servo_enable_o, 4'he)
        wr(IDX_TRIGGER, 32'h0000_1111);
        `CHK(ack_req, 4'h0)
        rd_chk(IDX_TRIGGER, 32'h0000_0000);
        wr(IDX_TRIGGER, 32'h0000_2000);
        wr(IDX_TRIGGER, 32'h0000_0000);
        rd_chk(IDX_TRIGGER, 32'h0000_2000);
        pulse(4'h2);
    endtask : t_disabled_zero

    task automatic t_series;
        wr(IDX_SERIES_PHONES, 32'h0000_0002);
        n = req_cnt[1];
        wr(IDX_TRIGGER, 32'h0000_0200);
        rd_chk(IDX_TRIGGER, 32'h0000_0200);
        // stand-in answers from the second update on, first one by hand
        auto_done <= 1'b1;
        pulse(4'h2);
        repeat (20) @(posedge clk_i);
        auto_done <= 1'b0;
        `CHK(req_cnt[1] - n, 3)
        rd_chk(IDX_TRIGGER, 32'h0000_0000);
    endtask : t_series

    task automatic t_startup_offset;
        wr(IDX_OFFSET_LR, 32'h0000_005a);
        `CHK(offset_value_o[31:24], 8'h5a)
        wr(IDX_TRIGGER, 32'h0000_0048);
        rd_chk(IDX_TRIGGER, 32'h0000_0848);
        `CHK(update_startup_o, 4'h4)
        `CHK(update_offset_write_o, 4'h8)
        pulse(4'hc);
        rd_chk(IDX_DONE, 32'h0000_0c00);
        rd_chk(IDX_TRIGGER, 32'h0000_0000);
    endtask : t_startup_offset

    task automatic t_periodic;
        wr(IDX_ENABLE, 32'h0000_000f);
        wr(IDX_SERIES_PHONES, 32'h0000_0000);
        wr(IDX_SERIES_LINE, 32'h0000_0000);
        auto_done <= 1'b1;
        for (int code = 1; code < 3; code++) begin
            wr(IDX_INTERVAL, 32'(code));
            n = req_cnt[3];
            repeat ((TICK << code) * 4) @(posedge clk_i);
            `CHK(gap[0], TICK << code)
            `CHK(gap[1], TICK << code)
            `CHK(req_cnt[3], n)
        end
        wr(IDX_INTERVAL, 32'h0000_0100);
        repeat (4) @(posedge clk_i);
        n = req_cnt[0];
        repeat (40) @(posedge clk_i);
        `CHK(gap[3], TICK * 2)
        `CHK(req_cnt[0], n)
        wr(IDX_INTERVAL, 32'h0000_0000);
        auto_done <= 1'b0;
    endtask : t_periodic

    // =========================================================
    // verdict
    // =========================================================
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    // main sequence: reset for 20 cycles, then each scenario in turn
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_single_irq();
        t_disabled_zero();
        t_series();
        t_startup_offset();
        t_periodic();
        end_sim();
    end
endmodule : dcs_servo_trigger_bench
